// file: act_pkg.sv
// Constants for the activity-driven processor clock throttle.
// Assumes a 100 MHz system clock and a 32-bit classic Wishbone register port.
package act_pkg;

    // ****************************************************************
    // Clock and register map
    // ****************************************************************
    localparam int unsigned CLK_PERIOD_NS = 10;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_SOURCE_MASK   = 8'hdf;
    localparam logic [7:0] IDX_INACTIVE_STEP = 8'he0;
    localparam logic [7:0] IDX_ACTIVE_STEP   = 8'he1;
    localparam logic [7:0] IDX_ACTIVITY_LVL  = 8'he2;
    localparam logic [7:0] IDX_THROTTLE_CTRL = 8'he3;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int MASK_IO_RANGE_BIT    = 7;
    localparam int MASK_DISPLAY_MEM_BIT = 6;
    localparam int MASK_DISK_IO_BIT     = 5;
    localparam int MASK_IRQ_LINES_BIT   = 4;
    localparam int MASK_SERIAL_IO_BIT   = 3;
    localparam int MASK_CARD_SLOT_BIT   = 2;
    localparam int MASK_KEYBOARD_IO_BIT = 1;
    localparam int MASK_PROG_CS_BIT     = 0;
    localparam int CTRL_ENABLE_BIT      = 7;
    localparam int CTRL_RATE_LSB        = 0;
    localparam int CTRL_RATE_W          = 3;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [7:0] MASK_RST       = 8'hef;
    localparam logic [7:0] INACT_STEP_RST = 8'h00;
    localparam logic [7:0] ACT_STEP_RST   = 8'h00;
    localparam logic [7:0] LEVEL_RST      = 8'hff;
    localparam logic [7:0] LEVEL_EMPTY    = 8'h00;
    localparam logic [2:0] RATE_RST       = 3'h0;

    // ****************************************************************
    // Sampling periods in nanoseconds
    // ****************************************************************
    localparam int unsigned PERIOD0_NS = 61000;
    localparam int unsigned PERIOD1_NS = 122000;
    localparam int unsigned PERIOD2_NS = 244000;
    localparam int unsigned PERIOD3_NS = 488000;
    localparam int unsigned PERIOD4_NS = 976000;
    localparam int unsigned PERIOD5_NS = 1950000;
    localparam int unsigned PERIOD6_NS = 3910000;
    localparam int unsigned PERIOD7_NS = 7810000;
    localparam int unsigned PERIOD0_CYC = PERIOD0_NS / CLK_PERIOD_NS;
    localparam int unsigned PERIOD1_CYC = PERIOD1_NS / CLK_PERIOD_NS;
    localparam int unsigned PERIOD2_CYC = PERIOD2_NS / CLK_PERIOD_NS;
    localparam int unsigned PERIOD3_CYC = PERIOD3_NS / CLK_PERIOD_NS;
    localparam int unsigned PERIOD4_CYC = PERIOD4_NS / CLK_PERIOD_NS;
    localparam int unsigned PERIOD5_CYC = PERIOD5_NS / CLK_PERIOD_NS;
    localparam int unsigned PERIOD6_CYC = PERIOD6_NS / CLK_PERIOD_NS;
    localparam int unsigned PERIOD7_CYC = PERIOD7_NS / CLK_PERIOD_NS;
    localparam int          PCNT_W      = 20;

    // ****************************************************************
    // State of the throttle
    // ****************************************************************
    typedef struct packed {
        logic [7:0]        mask;
        logic [7:0]        inact_step;
        logic [7:0]        act_step;
        logic [7:0]        level;
        logic              enable;
        logic [2:0]        rate;
        logic [PCNT_W-1:0] pcnt;
        logic              seen;
        logic              req;
        logic              ack;
        logic [31:0]       dat;
    } act_state_s;

endpackage : act_pkg

// file: act_throttle.sv
// Activity-driven processor clock throttle with a classic Wishbone slave.
// Assumes activity strobes are synchronous one-or-more-cycle levels on clk_i
// and that the clock generator acts on slow_req_o as a level.
`timescale 1ns/1ps

module act_throttle
    import act_pkg::*;
#(
    parameter int unsigned PERIOD_CYC [0:7] = '{PERIOD0_CYC, PERIOD1_CYC, PERIOD2_CYC,
                                                 PERIOD3_CYC, PERIOD4_CYC, PERIOD5_CYC,
                                                 PERIOD6_CYC, PERIOD7_CYC}
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [9:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    input  wire logic        io_range_hit_i,
    input  wire logic        display_wr_i,
    input  wire logic        disk_io_i,
    input  wire logic        irq_activity_i,
    input  wire logic        serial_io_i,
    input  wire logic        card_slot_i,
    input  wire logic        keyboard_io_i,
    input  wire logic        prog_cs_i,
    output logic             slow_req_o
);

    // ****************************************************************
    // Helpers
    // ****************************************************************
    act_state_s st_r;
    act_state_s st_nxt;
    logic [7:0] hits;
    logic [7:0] live_hits;
    logic       bus_req;
    logic       wr_lane0;
    logic [7:0] widx;
    logic       tick;

    // Period length for a rate code, less one so the counter ends on it
    function automatic logic [PCNT_W-1:0] period_last(input logic [2:0] code);
        period_last = PCNT_W'(PERIOD_CYC[code] - 1);
    endfunction : period_last

    // Unsigned add clamped at all ones
    function automatic logic [7:0] sat_up(input logic [7:0] lvl, input logic [7:0] stp);
        logic [8:0] sum;
        sum = {1'b0, lvl} + {1'b0, stp};
        sat_up = sum[8] ? LEVEL_RST : sum[7:0];
    endfunction : sat_up

    // Signed add clamped to 0..255; a negative step drains the level
    function automatic logic [7:0] sat_signed(input logic [7:0] lvl, input logic [7:0] stp);
        logic signed [9:0] sum;
        sum = $signed({2'b00, lvl}) + $signed({{2{stp[7]}}, stp});
        if (sum < 0) begin
            sat_signed = LEVEL_EMPTY;
        end else if (sum > 10'sd255) begin
            sat_signed = LEVEL_RST;
        end else begin
            sat_signed = sum[7:0];
        end
    endfunction : sat_signed

    // Source vector in mask bit order
    assign hits[MASK_IO_RANGE_BIT]    = io_range_hit_i;
    assign hits[MASK_DISPLAY_MEM_BIT] = display_wr_i;
    assign hits[MASK_DISK_IO_BIT]     = disk_io_i;
    assign hits[MASK_IRQ_LINES_BIT]   = irq_activity_i;
    assign hits[MASK_SERIAL_IO_BIT]   = serial_io_i;
    assign hits[MASK_CARD_SLOT_BIT]   = card_slot_i;
    assign hits[MASK_KEYBOARD_IO_BIT] = keyboard_io_i;
    assign hits[MASK_PROG_CS_BIT]     = prog_cs_i;

    // A set mask bit drops its source; a clear one lets it count
    assign live_hits = hits & ~st_r.mask;

    // New request only while no ack is outstanding, so each access acks once
    assign bus_req  = cyc_i & stb_i & ~st_r.ack;
    assign wr_lane0 = bus_req & we_i & sel_i[0];
    assign widx     = adr_i[9:2];

    // Period end; the compare is >= so that a rate lowered mid-period ends the
    // period at once instead of running the counter round its full range
    assign tick     = st_r.enable && (st_r.pcnt >= period_last(st_r.rate));

    // ****************************************************************
    // Next-state logic
    // ****************************************************************
    always_comb begin
        st_nxt = st_r;
        // Sampling: paused while disabled, counter restarts on enable
        if (!st_r.enable) begin
            st_nxt.pcnt = '0;
            st_nxt.seen = 1'b0;
        end else if (tick) begin
            st_nxt.pcnt = '0;
            st_nxt.seen = 1'b0;
            // Activity in the last cycle still belongs to this period
            if (st_r.seen || (|live_hits)) begin
                st_nxt.level = sat_up(st_r.level, st_r.act_step);
            end else begin
                st_nxt.level = sat_signed(st_r.level, st_r.inact_step);
            end
        end else begin
            st_nxt.pcnt = st_r.pcnt + 1'b1;
            st_nxt.seen = st_r.seen | (|live_hits);
        end
        // Register writes; a level write wins over a same-cycle period update
        if (wr_lane0) begin
            case (widx)
                IDX_SOURCE_MASK:   st_nxt.mask       = dat_i[7:0];
                IDX_INACTIVE_STEP: st_nxt.inact_step = dat_i[7:0];
                IDX_ACTIVE_STEP:   st_nxt.act_step   = dat_i[7:0];
                IDX_ACTIVITY_LVL:  st_nxt.level      = dat_i[7:0];
                IDX_THROTTLE_CTRL: begin
                    st_nxt.enable = dat_i[CTRL_ENABLE_BIT];
                    st_nxt.rate   = dat_i[CTRL_RATE_LSB +: CTRL_RATE_W];
                end
                default: ;
            endcase
        end
        // Hysteresis: set at empty, cleared only at full
        if (st_nxt.level == LEVEL_EMPTY) begin
            st_nxt.req = 1'b1;
        end else if (st_nxt.level == LEVEL_RST) begin
            st_nxt.req = 1'b0;
        end
        // Answer every access one cycle later; unmapped reads give zero
        st_nxt.ack = bus_req;
        st_nxt.dat = '0;
        if (bus_req && !we_i) begin
            case (widx)
                IDX_SOURCE_MASK:   st_nxt.dat[7:0] = st_r.mask;
                IDX_INACTIVE_STEP: st_nxt.dat[7:0] = st_r.inact_step;
                IDX_ACTIVE_STEP:   st_nxt.dat[7:0] = st_r.act_step;
                IDX_ACTIVITY_LVL:  st_nxt.dat[7:0] = st_r.level;
                IDX_THROTTLE_CTRL: begin
                    st_nxt.dat[CTRL_ENABLE_BIT]                   = st_r.enable;
                    st_nxt.dat[CTRL_RATE_LSB +: CTRL_RATE_W]      = st_r.rate;
                end
                default: st_nxt.dat = '0;
            endcase
        end
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r.mask       <= MASK_RST;
            st_r.inact_step <= INACT_STEP_RST;
            st_r.act_step   <= ACT_STEP_RST;
            st_r.level      <= LEVEL_RST;
            st_r.enable     <= 1'b0;
            st_r.rate       <= RATE_RST;
            st_r.pcnt       <= '0;
            st_r.seen       <= 1'b0;
            st_r.req        <= 1'b0;
            st_r.ack        <= 1'b0;
            st_r.dat        <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs come straight from the state flops
    assign dat_o      = st_r.dat;
    assign ack_o      = st_r.ack;
    assign slow_req_o = st_r.req;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    logic       chk_valid;
    logic [7:0] exp_up;
    logic [7:0] exp_dn;
    assign exp_up = sat_up(st_r.level, st_r.act_step);
    assign exp_dn = sat_signed(st_r.level, st_r.inact_step);

    always_ff @(posedge clk_i) begin
        chk_valid <= ~rst_i;
    end

    // Reset values are checked on the edge after every reset edge
    a_reset_state: assert property (disable iff (1'b0)
        rst_i ##1 1'b1 |-> (st_r.mask == 8'hef) && (st_r.level == 8'hff) && !st_r.enable
                         && (st_r.inact_step == 8'h00) && (st_r.rate == 3'h0) && !slow_req_o)
        else $error("register reset values wrong");
    a_mask_gates: assert property (
        (st_r.enable && !tick && ((hits & ~st_r.mask) != 8'h00)) |=> st_r.seen)
        else $error("unmasked activity not recorded");
    a_masked_quiet: assert property (
        $rose(st_r.seen) |-> $past((hits & ~st_r.mask) != 8'h00))
        else $error("masked source counted as activity");
    a_active_add: assert property (
        (tick && (st_r.seen || (|live_hits)) && !wr_lane0) |=> st_r.level == $past(exp_up))
        else $error("active step not applied");
    a_inactive_add: assert property (
        (tick && !st_r.seen && !(|live_hits) && !wr_lane0) |=> st_r.level == $past(exp_dn))
        else $error("inactive step not applied");
    a_req_at_empty: assert property (
        (chk_valid && st_r.level == 8'h00) |-> slow_req_o)
        else $error("no request at empty level");
    a_req_clear_full: assert property (
        (chk_valid && st_r.level == 8'hff) |-> !slow_req_o)
        else $error("request held at full level");
    a_req_rise_cause: assert property (
        $rose(slow_req_o) |-> st_r.level == 8'h00)
        else $error("request raised above empty");
    a_paused_level: assert property (
        (!st_r.enable && !wr_lane0) |=> $stable(st_r.level))
        else $error("level moved while paused");
    a_ack_single: assert property (
        ack_o |=> !ack_o)
        else $error("ack held for two cycles");

    // ****************************************************************
    // Bus checks
    // ****************************************************************
    // Helper flags for the register write checks
    logic wr_mask;
    logic wr_istep;
    logic wr_level;
    logic wr_ctrl;
    assign wr_mask  = wr_lane0 && (widx == IDX_SOURCE_MASK);
    assign wr_istep = wr_lane0 && (widx == IDX_INACTIVE_STEP);
    assign wr_level = wr_lane0 && (widx == IDX_ACTIVITY_LVL);
    assign wr_ctrl  = wr_lane0 && (widx == IDX_THROTTLE_CTRL);

    // Every taken request is answered on the very next edge
    a_ack_follows: assert property (
        (cyc_i && stb_i && !ack_o) |=> ack_o)
        else $error("request not acknowledged");

    // No answer without a request standing in the cycle before
    a_ack_cause: assert property (
        ack_o |-> $past(cyc_i && stb_i))
        else $error("ack without a request");

    // Read data is zero whenever no answer stands
    a_dat_idle: assert property (
        !ack_o |-> (dat_o == 32'h0000_0000))
        else $error("read data outside an answer");

    // Registers are one byte wide, upper lanes never carry data
    a_dat_upper: assert property (
        dat_o[31:8] == 24'h00_0000)
        else $error("upper read lanes not zero");

    // A write answer carries no data
    a_write_dat: assert property (
        (ack_o && $past(we_i)) |-> (dat_o == 32'h0000_0000))
        else $error("data on a write answer");

    // ****************************************************************
    // Register and sampling checks
    // ****************************************************************
    // A lane 0 write lands in the addressed register on the taking edge
    a_mask_write: assert property (
        wr_mask |=> (st_r.mask == $past(dat_i[7:0])))
        else $error("mask write lost");

    // Inactive step keeps the full signed byte
    a_step_write: assert property (
        wr_istep |=> (st_r.inact_step == $past(dat_i[7:0])))
        else $error("inactive step write lost");

    // A level load wins over a period end in the same cycle
    a_level_write: assert property (
        wr_level |=> (st_r.level == $past(dat_i[7:0])))
        else $error("level load lost");

    // Enable and rate follow a control write
    a_ctrl_write: assert property (
        wr_ctrl |=> (st_r.enable == $past(dat_i[CTRL_ENABLE_BIT]))
                    && (st_r.rate == $past(dat_i[CTRL_RATE_LSB +: CTRL_RATE_W])))
        else $error("control write lost");

    // Steps and mask only change when written
    a_steps_held: assert property (
        !wr_lane0 |=> $stable(st_r.inact_step) && $stable(st_r.act_step) && $stable(st_r.mask))
        else $error("register changed without a write");

    // The period counter rests at zero while paused
    a_pcnt_paused: assert property (
        !st_r.enable |=> (st_r.pcnt == '0))
        else $error("counter ran while paused");

    // A period end restarts the count
    a_tick_restart: assert property (
        tick |=> (st_r.pcnt == '0))
        else $error("counter not restarted");

    // With the rate steady the count never passes the period end
    a_pcnt_bound: assert property (
        (st_r.enable && $stable(st_r.rate)) |-> (st_r.pcnt <= period_last(st_r.rate)))
        else $error("counter past period end");

    // An active period never lowers the level
    a_up_no_wrap: assert property (
        (tick && (st_r.seen || (|live_hits)) && !wr_lane0) |=> (st_r.level >= $past(st_r.level)))
        else $error("active step wrapped");

    // A negative quiet step never raises the level
    a_dn_no_wrap: assert property (
        (tick && !st_r.seen && !(|live_hits) && st_r.inact_step[7] && !wr_lane0)
        |=> (st_r.level <= $past(st_r.level)))
        else $error("inactive step wrapped");

    // Between the two ends the request keeps its value
    a_req_hold: assert property (
        (chk_valid && (st_r.level != 8'h00) && (st_r.level != 8'hff)) |-> $stable(slow_req_o))
        else $error("request moved between the ends");

    // The request only drops once the level is full
    a_req_fall_cause: assert property (
        $fell(slow_req_o) |-> (st_r.level == 8'hff))
        else $error("request dropped below full");

    c_req_rise:   cover property ($rose(slow_req_o));
    c_req_fall:   cover property ($fell(slow_req_o));
    c_active_tk:  cover property (tick && st_r.seen);
    c_quiet_tk:   cover property (tick && !st_r.seen && st_r.inact_step[7]);
    c_level_load: cover property (wr_level);

endmodule : act_throttle

// file: act_far_side.sv
// Model of the host-side activity sources and the processor clock generator.
// Assumes the bench names the busy sources; every line changes only on clk_i.
`timescale 1ns/1ps

module act_far_side (
    input  wire logic       clk_i,
    input  wire logic [7:0] busy_i,
    input  wire logic       slow_req_i,
    output logic      [7:0] act_o,
    output logic            cpu_clk_en_o
);
    // ****************************************************************
    // Host sources and clock generator
    // ****************************************************************
    // Strobes are registered so they only move at the throttle's sampling edge
    always_ff @(posedge clk_i) begin
        act_o <= busy_i;
    end

    // Processor clock is gated for as long as a slow/stop request stands
    always_ff @(posedge clk_i) begin
        cpu_clk_en_o <= ~slow_req_i;
    end
endmodule : act_far_side

// file: testbench.sv
// Self-checking bench for the activity clock throttle.
// Assumes short sampling periods; read data is checked by a queue monitor.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_errors++; \
    $display("[ERR] %s expected %h seen %h", nm, e, g); end end

module testbench import act_pkg::*;;
    localparam int unsigned P [0:7] = '{8, 16, 32, 64, 128, 256, 512, 1024};
    localparam logic [9:0]  A_MSK   = {IDX_SOURCE_MASK, 2'b00};
    localparam logic [9:0]  A_IST   = {IDX_INACTIVE_STEP, 2'b00};
    localparam logic [9:0]  A_AST   = {IDX_ACTIVE_STEP, 2'b00};
    localparam logic [9:0]  A_LVL   = {IDX_ACTIVITY_LVL, 2'b00};
    localparam logic [9:0]  A_CTL   = {IDX_THROTTLE_CTRL, 2'b00};
    logic        clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
    logic [9:0]  adr_i = 10'h000;
    logic [3:0]  sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0000_0000, dat_o, e_v;
    logic        ack_o, slow_req_o, cpu_clk_en;
    logic [7:0]  busy = 8'h00, act, v, m;
    logic [31:0] expq [$];
    integer      seed = 32'h1577;
    int          n_errors = 0, samples_checked = 0, n;

    act_throttle #(.PERIOD_CYC(P)) uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
        .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
        .dat_o(dat_o), .ack_o(ack_o), .io_range_hit_i(act[7]), .display_wr_i(act[6]),
        .disk_io_i(act[5]), .irq_activity_i(act[4]), .serial_io_i(act[3]),
        .card_slot_i(act[2]), .keyboard_io_i(act[1]), .prog_cs_i(act[0]),
        .slow_req_o(slow_req_o));
    act_far_side far (.clk_i(clk_i), .busy_i(busy), .slow_req_i(slow_req_o),
        .act_o(act), .cpu_clk_en_o(cpu_clk_en));

    // ****************************************************************
    // Clock, bus tasks and read monitor
    // ****************************************************************
    initial begin
        forever #5 clk_i = ~clk_i;
    end

    // Classic cycle: hold everything until ack is sampled, then release
    task automatic wb(input logic w, input logic [9:0] a, input logic [7:0] d);
        int t;
        t = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        sel_i <= 4'h1;
        dat_i <= {24'h00_0000, d};
        do begin
            @(posedge clk_i);
            t++;
        end while (ack_o !== 1'b1 && t < 20);
        if (t >= 20) n_errors++;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask : wb

    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        wb(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [9:0] a, input logic [7:0] e);
        expq.push_back({24'h00_0000, e});
        wb(1'b0, a, 8'h00);
    endtask : rd

    // Read data is judged at the edge that samples ack, against the oldest note
    always @(posedge clk_i) begin
        if (ack_o === 1'b1 && we_i === 1'b0) begin
            if (expq.size() == 0) n_errors++;
            else begin
                e_v = expq.pop_front();
                `CHK("dat_o", e_v, dat_o)
            end
        end
    end

    task automatic print_verdict;
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : print_verdict

    // Hang guard, well beyond the longest expected run
    initial begin
        repeat (30000) @(posedge clk_i);
        n_errors++;
        print_verdict;
    end

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(A_MSK, 8'hef);
        rd(A_IST, 8'h00);
        rd(A_AST, 8'h00);
        rd(A_LVL, 8'hff);
        rd(A_CTL, 8'h00);
        rd(10'h000, 8'h00);
        `CHK("slow_req", 1'b0, slow_req_o)
        v = 8'($random(seed));
        wr(A_IST, v);
        rd(A_IST, v);
        // Largest negative step must clamp at zero rather than wrap
        wr(A_IST, 8'h80);
        wr(A_CTL, 8'h80);
        repeat (40) @(posedge clk_i);
        wr(A_CTL, 8'h00);
        rd(A_LVL, 8'h00);
        `CHK("slow_req", 1'b1, slow_req_o)
        `CHK("cpu_clk_en", 1'b0, cpu_clk_en)
        // One source unmasked at a time; the last pass masks all under noise
        wr(A_IST, 8'h00);
        wr(A_AST, 8'hc0);
        for (int i = 0; i < 9; i++) begin
            m = (i < 8) ? ~(8'h01 << i) : 8'hff;
            wr(A_MSK, m);
            wr(A_LVL, 8'h00);
            busy <= (i < 8) ? (8'h01 << i) : 8'($random(seed));
            wr(A_CTL, 8'h80);
            repeat (30) @(posedge clk_i);
            wr(A_CTL, 8'h00);
            busy <= 8'h00;
            rd(A_LVL, (i < 8) ? 8'hff : 8'h00);
            `CHK("slow_req", (i < 8) ? 1'b0 : 1'b1, slow_req_o)
        end
        // Each rate code: count cycles from enable until the level hits zero
        wr(A_IST, 8'hff);
        for (int k = 0; k < 8; k++) begin
            wr(A_CTL, 8'h00);
            wr(A_LVL, 8'hff);
            wr(A_LVL, 8'h01);
            `CHK("slow_req", 1'b0, slow_req_o)
            wr(A_CTL, 8'h80 | 8'(k));
            n = 0;
            while (slow_req_o !== 1'b1 && n < 1100) begin
                @(posedge clk_i);
                n++;
            end
            `CHK("period", 1'b1, (n >= P[k] - 1 && n <= P[k] + 1))
        end
        // Second reset in mid-run brings back the full level and drops the request
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(A_LVL, 8'hff);
        `CHK("slow_req", 1'b0, slow_req_o)
        print_verdict;
    end
endmodule : testbench
